// File: pkg/valve_head_consts.svh
// Named constants for the valve head attribute block.
// Assumes a 50 MHz system clock.
`ifndef VALVE_HEAD_CONSTS_SVH
`define VALVE_HEAD_CONSTS_SVH
`define CLK_HZ 50000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define KEY_HOLD_MS 5000
`define TRAVEL_MS 10000
`define FLASH_MS 250
`define CLS_ASSEMBLY 8'h04
`define CLS_VALVE 8'h96
`define INST_ONE 8'h01
`define ATTR_PROCESS 8'h03
`define ATTR_SAFE_POS 8'h06
`define ATTR_SAFE_MODE 8'h07
`define ATTR_TEACH 8'h08
`define BIT_BOTTOM 0
`define BIT_TOP 1
`define BIT_VALVE 0
`define BIT_RETAIN 0
`define BIT_TEACH_DONE 0
`define BIT_TEACH_FAIL 1
`define BYTE_ZERO 8'h00
`define RESET_SAFE_POS 1'b0
`define RESET_SAFE_MODE 1'b0
`define CNT_ZERO 32'h0000_0000
`define CNT_ONE 32'h0000_0001
`endif

// File: pkg/valve_head_pkg.sv
// Types for the valve head attribute block.
// Assumes nothing beyond the SystemVerilog language.
package valve_head_pkg;
    typedef enum logic [4:0] {
        T_IDLE   = 5'b00001,
        T_BOTTOM = 5'b00010,
        T_RISE   = 5'b00100,
        T_TOP    = 5'b01000,
        T_FALL   = 5'b10000
    } teach_state_t;

    typedef struct packed {
        logic         bot_s1;
        logic         bot_s2;
        logic         top_s1;
        logic         top_s2;
        logic         key_s1;
        logic         key_s2;
        logic         valve_cmd;
        logic         safe_mode;
        logic         safe_pos;
        logic         valve;
        logic [7:0]   in_byte;
        logic         in_valid;
        logic         cos;
        logic         ack;
        logic         err;
        logic [7:0]   rdata;
        teach_state_t state;
        logic [31:0]  key_cnt;
        logic [31:0]  step_cnt;
        logic [31:0]  blink_cnt;
        logic         blink;
        logic         fail;
        logic         done;
        logic         result;
        logic         yellow;
        logic         led_g;
        logic         led_r;
    } core_t;
endpackage

// File: rtl/valve_head_fieldbus_attributes.sv
// Process data, safety configuration and teach logic of a valve head.
// Assumes a fieldbus stack on the same clock delivering decoded
// explicit requests, cyclic output data and link status.
//
// Overview of operation
// [RULE1] One input assembly and one output assembly carry all process data.
// [RULE2] Polled and strobed exchange cyclic; change of state sent on input change.
// [RULE3] Class 4, instance 1, attribute 3: get reads inputs, set writes outputs.
// [RULE4] Input byte: bit 0 bottom reached, bit 1 top reached, rest zero.
// [RULE5] Output bit 0 drives the pilot valve; master keeps upper bits zero.
// [RULE6] Safety mode at 150/1/7: bit 0 zero uses safety position, one retains.
// [RULE7] Safety position at 150/1/6: bit 0 is valve state on bus fault.
// [RULE8] Safety attributes stay readable and writable during a bus fault.
// [RULE9] Teach: record bottom, valve on, travel up, record top, valve off, return.
// [RULE10] Holding the local teach key about five seconds starts teach.
// [RULE11] Yellow status indicator flashes while teach runs.
// [RULE12] Network valve commands are ignored while teach runs.
// [RULE13] Writing 150/1/8 with bit 0 zero starts teach; result bit read-only.
// [RULE14] Teach read: bit 0 zero running, one done; bit 1 result; rest zero.
// [RULE15] Bus fault shows flashing green, flashing red or steady red.
// [RULE16] On bus failure the valve takes the programmable safety setting; while teach runs the valve follows the teach sequence instead.
// [RULE17] Teach result bit: zero success, one defective.
// [RULE18] A teach start while teach already runs is ignored.
`timescale 1ns/1ps
`include "valve_head_consts.svh"

module valve_head_fieldbus_attributes
    import valve_head_pkg::*;
#(
    parameter logic [31:0] KEY_HOLD_CYC = 32'(`KEY_HOLD_MS * `CYC_PER_MS),
    parameter logic [31:0] TRAVEL_CYC   = 32'(`TRAVEL_MS * `CYC_PER_MS),
    parameter logic [31:0] FLASH_CYC    = 32'(`FLASH_MS * `CYC_PER_MS)
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       bottom_pin,
    input  wire logic       top_pin,
    input  wire logic       teach_key_n,
    input  wire logic       bus_connected,
    input  wire logic       io_timeout,
    input  wire logic       bus_critical,
    input  wire logic       io_poll,
    input  wire logic       io_out_valid,
    input  wire logic [7:0] io_out_byte,
    input  wire logic       attr_req,
    input  wire logic       attr_set,
    input  wire logic [7:0] attr_class,
    input  wire logic [7:0] attr_instance,
    input  wire logic [7:0] attr_attribute,
    input  wire logic [7:0] attr_wdata,
    output logic            pilot_valve_output,
    output logic [7:0]      io_in_byte,
    output logic            io_in_valid,
    output logic            cos_send,
    output logic            attr_ack,
    output logic            attr_err,
    output logic [7:0]      attr_rdata,
    output logic            teach_led_yellow,
    output logic            bus_led_green,
    output logic            bus_led_red
);

    core_t q;
    core_t d;

    // True when the request addresses the given class, instance one and attribute
    function automatic logic path_is(
        input logic [7:0] cls,
        input logic [7:0] att
    );
        path_is = (attr_class == cls) && (attr_instance == `INST_ONE) && (attr_attribute == att);
    endfunction

    // Places one bit at the given position of an otherwise zero byte
    function automatic logic [7:0] bit_byte(
        input logic b,
        input int   pos
    );
        logic [7:0] r;
        r = `BYTE_ZERO;
        r[pos] = b;
        bit_byte = r;
    endfunction

    logic       bus_fault;
    logic       key_start;
    logic       net_start;
    logic       running;
    logic [7:0] in_now;

    always_comb begin
        d = q;
        bus_fault = (!bus_connected) || io_timeout || bus_critical;
        running = (q.state != T_IDLE);
        net_start = 1'b0;

        // Pin synchronisers
        d.bot_s1 = bottom_pin;
        d.bot_s2 = q.bot_s1;
        d.top_s1 = top_pin;
        d.top_s2 = q.top_s1;
        d.key_s1 = teach_key_n;
        d.key_s2 = q.key_s1;

        // Input assembly, upper bits always zero
        in_now = bit_byte(q.bot_s2, `BIT_BOTTOM) | bit_byte(q.top_s2, `BIT_TOP); // [RULE4] [RULE1]
        d.in_byte = in_now;
        d.cos = (in_now != q.in_byte); // [RULE2]
        d.in_valid = io_poll; // [RULE2]

        // Cyclic output data; ignored during teach
        if (io_out_valid && !running) begin
            d.valve_cmd = io_out_byte[`BIT_VALVE]; // [RULE5] [RULE12]
        end

        // Explicit attribute services, not gated by bus state
        d.ack = attr_req;
        d.err = 1'b0;
        d.rdata = `BYTE_ZERO;
        if (attr_req) begin
            if (path_is(`CLS_ASSEMBLY, `ATTR_PROCESS)) begin
                if (attr_set) begin
                    if (!running) begin
                        d.valve_cmd = attr_wdata[`BIT_VALVE]; // [RULE3] [RULE12]
                    end
                end else begin
                    d.rdata = in_now; // [RULE3]
                end
            end else if (path_is(`CLS_VALVE, `ATTR_SAFE_MODE)) begin
                if (attr_set) begin
                    d.safe_mode = attr_wdata[`BIT_RETAIN]; // [RULE6] [RULE8]
                end else begin
                    d.rdata = bit_byte(q.safe_mode, `BIT_RETAIN); // [RULE6] [RULE8]
                end
            end else if (path_is(`CLS_VALVE, `ATTR_SAFE_POS)) begin
                if (attr_set) begin
                    d.safe_pos = attr_wdata[`BIT_VALVE]; // [RULE7] [RULE8]
                end else begin
                    d.rdata = bit_byte(q.safe_pos, `BIT_VALVE); // [RULE7] [RULE8]
                end
            end else if (path_is(`CLS_VALVE, `ATTR_TEACH)) begin
                if (attr_set) begin
                    net_start = !attr_wdata[`BIT_TEACH_DONE]; // [RULE13]
                end else begin
                    d.rdata = bit_byte(q.done, `BIT_TEACH_DONE)
                            | bit_byte(q.done & q.result, `BIT_TEACH_FAIL); // [RULE14]
                end
            end else begin
                d.err = 1'b1;
            end
        end

        // Key hold timer; fires once per press
        if (!q.key_s2) begin
            if (q.key_cnt != KEY_HOLD_CYC) begin
                d.key_cnt = q.key_cnt + `CNT_ONE;
            end
        end else begin
            d.key_cnt = `CNT_ZERO;
        end
        key_start = !q.key_s2 && (q.key_cnt == KEY_HOLD_CYC - `CNT_ONE); // [RULE10]

        // Flash phase shared by the indicators
        if (q.blink_cnt >= FLASH_CYC - `CNT_ONE) begin
            d.blink_cnt = `CNT_ZERO;
            d.blink = !q.blink;
        end else begin
            d.blink_cnt = q.blink_cnt + `CNT_ONE;
        end

        // Valve outside teach
        if (!running) begin
            if (bus_fault) begin
                if (!q.safe_mode) begin
                    d.valve = q.safe_pos; // [RULE16] [RULE6] [RULE7]
                end
            end else begin
                d.valve = q.valve_cmd; // [RULE5]
            end
        end

        // Teach sequence
        case (q.state)
            T_IDLE: begin
                if (key_start || net_start) begin // [RULE18]
                    d.state = T_BOTTOM;
                    d.done = 1'b0;
                    d.fail = 1'b0;
                end
            end
            T_BOTTOM: begin
                d.fail = !q.bot_s2; // [RULE9]
                d.valve = 1'b1; // [RULE9]
                d.step_cnt = `CNT_ZERO;
                d.state = T_RISE;
            end
            T_RISE: begin
                d.valve = 1'b1;
                d.step_cnt = q.step_cnt + `CNT_ONE;
                if (q.top_s2) begin
                    d.state = T_TOP; // [RULE9]
                end else if (q.step_cnt >= TRAVEL_CYC - `CNT_ONE) begin
                    d.fail = 1'b1;
                    d.state = T_TOP;
                end
            end
            T_TOP: begin
                d.fail = q.fail || !q.top_s2; // [RULE9]
                d.valve = 1'b0; // [RULE9]
                d.step_cnt = `CNT_ZERO;
                d.state = T_FALL;
            end
            T_FALL: begin
                d.valve = 1'b0;
                d.step_cnt = q.step_cnt + `CNT_ONE;
                if (q.bot_s2 || (q.step_cnt >= TRAVEL_CYC - `CNT_ONE)) begin
                    d.result = q.fail || !q.bot_s2; // [RULE17]
                    d.done = 1'b1; // [RULE14]
                    d.state = T_IDLE; // [RULE9]
                end
            end
            default: begin
                d.state = T_IDLE;
                d.done = 1'b1;
            end
        endcase

        // Indicators
        d.yellow = running && q.blink; // [RULE11]
        if (bus_critical) begin
            d.led_g = 1'b0;
            d.led_r = 1'b1; // [RULE15]
        end else if (io_timeout) begin
            d.led_g = 1'b0;
            d.led_r = q.blink; // [RULE15]
        end else if (!bus_connected) begin
            d.led_g = q.blink; // [RULE15]
            d.led_r = 1'b0;
        end else begin
            d.led_g = 1'b1;
            d.led_r = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
            q.state <= T_IDLE;
            q.done <= 1'b1;
            q.key_s1 <= 1'b1;
            q.key_s2 <= 1'b1;
            q.safe_pos <= `RESET_SAFE_POS;
            q.safe_mode <= `RESET_SAFE_MODE;
        end else begin
            q <= d;
        end
    end

    assign pilot_valve_output = q.valve;
    assign io_in_byte = q.in_byte;
    assign io_in_valid = q.in_valid;
    assign cos_send = q.cos;
    assign attr_ack = q.ack;
    assign attr_err = q.err;
    assign attr_rdata = q.rdata;
    assign teach_led_yellow = q.yellow;
    assign bus_led_green = q.led_g;
    assign bus_led_red = q.led_r;

endmodule

// File: verification/valve_head_monitor.sv
// Checker for the valve head attribute block.
// Bound to the top module; sees its ports only, one clock domain.
`timescale 1ns/1ps
module valve_head_monitor (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       bus_critical,
    input wire logic       io_poll,
    input wire logic       attr_req,
    input wire logic       attr_set,
    input wire logic [7:0] attr_class,
    input wire logic [7:0] attr_instance,
    input wire logic [7:0] attr_attribute,
    input wire logic       io_in_valid,
    input wire logic       attr_ack,
    input wire logic       attr_err,
    input wire logic [7:0] attr_rdata,
    input wire logic       bus_led_green,
    input wire logic       bus_led_red
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire path_ok = attr_instance == 8'h01 && ((attr_class == 8'h04 && attr_attribute == 8'h03) ||
        (attr_class == 8'h96 && attr_attribute inside {8'h06, 8'h07, 8'h08}));
    a_ack_one_cycle: assert property (attr_req |=> attr_ack) else $error("no ack after request");
    a_no_stray_ack: assert property (!attr_req |=> !attr_ack) else $error("ack without request");
    a_path_error: assert property (attr_req |=> attr_err != $past(path_ok)) else $error("bad error flag");
    a_set_rdata_zero: assert property (attr_req && attr_set |=> attr_rdata == 8'h00) else $error("set data");
    a_read_upper_zero: assert property (attr_req && !attr_set && path_ok |=> attr_rdata[7:2] == 6'h00)
        else $error("unused read bits set");
    a_poll_answer: assert property (io_poll |=> io_in_valid) else $error("poll not answered");
    a_no_stray_valid: assert property (!io_poll |=> !io_in_valid) else $error("input valid without poll");
    a_critical_red: assert property (bus_critical ##1 bus_critical |-> bus_led_red && !bus_led_green)
        else $error("critical fault not steady red");
endmodule
bind valve_head_fieldbus_attributes valve_head_monitor u_valve_head_monitor (.clock, .rst_n, .bus_critical,
    .io_poll, .attr_req, .attr_set, .attr_class, .attr_instance, .attr_attribute, .io_in_valid, .attr_ack,
    .attr_err, .attr_rdata, .bus_led_green, .bus_led_red);

// File: verification/fieldbus_master.sv
// Bus master model: explicit attribute requests and cyclic output data.
// Driven through its tasks by the bench; same clock as the block.
`timescale 1ns/1ps
module fieldbus_master (
    input  wire logic       clock,
    input  wire logic       attr_ack,
    input  wire logic [7:0] attr_rdata,
    input  wire logic       attr_err,
    output logic            attr_req,
    output logic            attr_set,
    output logic [7:0]      attr_class,
    output logic [7:0]      attr_instance,
    output logic [7:0]      attr_attribute,
    output logic [7:0]      attr_wdata,
    output logic            io_out_valid,
    output logic            io_poll,
    output logic [7:0]      io_out_byte
);
    logic last_err = 1'b0;
    initial begin
        {attr_req, attr_set, io_out_valid, io_poll} = 4'h0;
        {attr_class, attr_instance, attr_attribute, attr_wdata, io_out_byte} = 40'h0;
    end
    // One request pulse; class, attribute and write data are scrambled once it has been taken, instance stays one
    task automatic access(input logic set, input logic [7:0] cls, att, wd, output logic [7:0] rd);
        rd = 8'hXX;
        @(posedge clock);
        {attr_req, attr_set, attr_class, attr_instance, attr_attribute, attr_wdata} <= {1'b1, set, cls, 8'h01, att, wd};
        @(posedge clock);
        {attr_req, attr_class, attr_attribute, attr_wdata} <= {1'b0, ~cls, ~att, ~wd};
        for (int i = 0; i < 4 && attr_ack !== 1'b1; i++) @(posedge clock);
        if (attr_ack === 1'b1) begin
            rd = attr_rdata;
            last_err = attr_err;
        end
    endtask
    // Callers keep bits 7..1 at zero
    task automatic send_out(input logic [7:0] b);
        @(posedge clock);
        {io_out_valid, io_poll, io_out_byte} <= {2'b11, b};
        @(posedge clock);
        {io_out_valid, io_poll, io_out_byte} <= {2'b00, ~b};
    endtask
endmodule

// File: verification/valve_head_fieldbus_attributes_tb.sv
// Self-checking bench for the valve head attribute block.
// Short counts; a ten-step actuator model moves the end sensors.
`timescale 1ns/1ps
module valve_head_fieldbus_attributes_tb;
    logic clock = 1'b0, rst_n = 1'b0, teach_key_n = 1'b1, bus_connected = 1'b1, io_timeout = 1'b0;
    logic bus_critical = 1'b0, stuck = 1'b0;
    logic attr_req, attr_set, io_out_valid, io_poll, pilot_valve_output, io_in_valid, cos_send;
    logic attr_ack, attr_err, teach_led_yellow, bus_led_green, bus_led_red;
    logic [7:0] attr_class, attr_instance, attr_attribute, attr_wdata, io_out_byte, io_in_byte, attr_rdata;
    int pos = 0, err_count = 0, checks_done = 0, cycles = 0;
    wire bottom_pin = pos == 0;
    wire top_pin = pos == 10;
    always #10 clock = ~clock;
    always @(posedge clock) begin
        if (pilot_valve_output && !stuck && pos < 10) pos <= pos + 1;
        else if (!pilot_valve_output && pos > 0) pos <= pos - 1;
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            close_out();
        end
    end
    valve_head_fieldbus_attributes #(.KEY_HOLD_CYC(32'd20), .TRAVEL_CYC(32'd50), .FLASH_CYC(32'd4))
        u_valve_head_fieldbus_attributes (.clock, .rst_n, .bottom_pin, .top_pin, .teach_key_n, .bus_connected,
        .io_timeout, .bus_critical, .io_poll, .io_out_valid, .io_out_byte, .attr_req, .attr_set, .attr_class,
        .attr_instance, .attr_attribute, .attr_wdata, .pilot_valve_output, .io_in_byte, .io_in_valid, .cos_send,
        .attr_ack, .attr_err, .attr_rdata, .teach_led_yellow, .bus_led_green, .bus_led_red);
    fieldbus_master u_fieldbus_master (.clock, .attr_ack, .attr_rdata, .attr_err, .attr_req, .attr_set, .attr_class,
        .attr_instance, .attr_attribute, .attr_wdata, .io_out_valid, .io_poll, .io_out_byte);
    task automatic chk(input logic [7:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic rd(input logic [7:0] cls, att, exp);
        logic [7:0] v;
        u_fieldbus_master.access(1'b0, cls, att, 8'h00, v);
        chk(v, exp);
    endtask
    task automatic wr(input logic [7:0] cls, att, wd);
        logic [7:0] v;
        u_fieldbus_master.access(1'b1, cls, att, wd, v);
    endtask
    task automatic t_reset_values();
        rd(8'h96, 8'h07, 8'h00);
        rd(8'h96, 8'h06, 8'h00);
        rd(8'h96, 8'h08, 8'h01);
        rd(8'h96, 8'h09, 8'h00);
        chk({7'h00, u_fieldbus_master.last_err}, 8'h01);
    endtask
    task automatic t_process();
        logic cos_seen;
        cos_seen = 1'b0;
        rd(8'h04, 8'h03, 8'h01);
        chk(io_in_byte, 8'h01);
        u_fieldbus_master.send_out(8'h01);
        repeat (2) @(posedge clock);
        chk({7'h00, pilot_valve_output}, 8'h01);
        repeat (14) begin
            @(posedge clock);
            cos_seen |= cos_send;
        end
        chk({7'h00, cos_seen}, 8'h01);
        chk(io_in_byte, 8'h02);
        rd(8'h04, 8'h03, 8'h02);
        wr(8'h04, 8'h03, 8'h00);
        repeat (14) @(posedge clock);
        rd(8'h04, 8'h03, 8'h01);
    endtask
    task automatic t_safety();
        wr(8'h96, 8'h06, 8'hFF);
        rd(8'h96, 8'h06, 8'h01);
        wr(8'h96, 8'h07, 8'h01);
        bus_connected <= 1'b0;
        repeat (4) @(posedge clock);
        chk({6'h00, bus_led_red, pilot_valve_output}, 8'h00);
        wr(8'h96, 8'h07, 8'h00);
        rd(8'h96, 8'h07, 8'h00);
        repeat (2) @(posedge clock);
        chk({7'h00, pilot_valve_output}, 8'h01);
        bus_critical <= 1'b1;
        repeat (3) @(posedge clock);
        chk({6'h00, bus_led_red, bus_led_green}, 8'h02);
        bus_critical <= 1'b0;
        bus_connected <= 1'b1;
        wr(8'h96, 8'h06, 8'h00);
        repeat (14) @(posedge clock);
        chk({6'h00, bus_led_red, bus_led_green}, 8'h01);
    endtask
    task automatic t_teach_net();
        logic seen;
        seen = 1'b0;
        wr(8'h96, 8'h08, 8'h00);
        rd(8'h96, 8'h08, 8'h00);
        u_fieldbus_master.send_out(8'h00);
        repeat (2) @(posedge clock);
        chk({7'h00, pilot_valve_output}, 8'h01);
        wr(8'h96, 8'h08, 8'h00);
        repeat (40) begin
            @(posedge clock);
            seen |= teach_led_yellow;
        end
        chk({7'h00, seen}, 8'h01);
        rd(8'h96, 8'h08, 8'h01);
        chk({7'h00, teach_led_yellow}, 8'h00);
    endtask
    task automatic t_teach_key();
        teach_key_n <= 1'b0;
        repeat (10) @(posedge clock);
        teach_key_n <= 1'b1;
        rd(8'h96, 8'h08, 8'h01);
        stuck <= 1'b1;
        teach_key_n <= 1'b0;
        repeat (30) @(posedge clock);
        teach_key_n <= 1'b1;
        rd(8'h96, 8'h08, 8'h00);
        repeat (80) @(posedge clock);
        rd(8'h96, 8'h08, 8'h03);
        stuck <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        t_reset_values();
        t_process();
        t_safety();
        t_teach_net();
        t_teach_key();
        close_out();
    end
endmodule
